/* File: core/psol_defs.vh */
// Constants for the position switch output logic.
`ifndef PSOL_DEFS_VH
`define PSOL_DEFS_VH
`define PSOL_CLK_HZ          25000000
`define PSOL_TOUCH_GONE_MS   5000
`define PSOL_TOUCH_GONE_CYC  ((`PSOL_CLK_HZ / 1000) * `PSOL_TOUCH_GONE_MS)
`define PSOL_LOCK_MS         3000
`define PSOL_LOCK_CYC        ((`PSOL_CLK_HZ / 1000) * `PSOL_LOCK_MS)
`define PSOL_PRESS_MIN_MS    100
`define PSOL_PRESS_MIN_CYC   ((`PSOL_CLK_HZ / 1000) * `PSOL_PRESS_MIN_MS)
`define PSOL_PRESS_MAX_MS    500
`define PSOL_PRESS_MAX_CYC   ((`PSOL_CLK_HZ / 1000) * `PSOL_PRESS_MAX_MS)
`define PSOL_HOLD_MS         2000
`define PSOL_HOLD_CYC        ((`PSOL_CLK_HZ / 1000) * `PSOL_HOLD_MS)
`define PSOL_LIFT_MS         2000
`define PSOL_LIFT_CYC        ((`PSOL_CLK_HZ / 1000) * `PSOL_LIFT_MS)
`define PSOL_ERR_HZ          4
`define PSOL_ERR_HALF_CYC    (`PSOL_CLK_HZ / (2 * `PSOL_ERR_HZ))
`define PSOL_LINK_HZ         2
`define PSOL_LINK_HALF_CYC   (`PSOL_CLK_HZ / (2 * `PSOL_LINK_HZ))
`define PSOL_OVL_HZ          8
`define PSOL_OVL_HALF_CYC    (`PSOL_CLK_HZ / (2 * `PSOL_OVL_HZ))
`define PSOL_POS_W           16
`define PSOL_UM_PER_LSB      10
`define PSOL_HYST_RST        16'h0032
`define PSOL_HYST_MIN        16'h0005
`define PSOL_HYST_MAX        16'h07D0
`define PSOL_CYL_HALF        16'h0096
`define PSOL_MODE_SINGLE     2'h0
`define PSOL_MODE_CYL        2'h1
`define PSOL_MODE_WINDOW     2'h2
`define PSOL_MODE_TWOPT      2'h3
`define PSOL_AOUT_W          12
`define PSOL_AOUT_FS         12'hFFF
`define PSOL_AOUT_4MA        12'h333
`endif

/* File: core/psol_keypad.v */
// Capacitive keypad timing: press, hold, lift, recalibration and lockout.
`timescale 1ns/1ps
`default_nettype none
`include "psol_defs.vh"
module psol_keypad #(
  parameter GONE_CYC  = `PSOL_TOUCH_GONE_CYC,
  parameter LOCK_CYC  = `PSOL_LOCK_CYC,
  parameter HOLD_CYC  = `PSOL_HOLD_CYC,
  parameter LIFT_CYC  = `PSOL_LIFT_CYC,
  parameter PMIN_CYC  = `PSOL_PRESS_MIN_CYC,
  parameter PMAX_CYC  = `PSOL_PRESS_MAX_CYC
) (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       touch_sync,
  input  wire       drift_flag,
  input  wire       bad_unlock,
  output reg        key_press,
  output reg        key_hold,
  output reg        key_lift,
  output reg        recal_pulse,
  output reg        key_locked
);
  reg  [27:0] on_reg;
  reg  [27:0] off_reg;
  reg  [27:0] drift_reg;
  reg  [27:0] lock_reg;
  reg         cand_reg;
  reg         held_reg;
  reg         lifted_reg;
  reg         prev_reg;
  wire        touch = touch_sync & ~key_locked;

  always @(posedge mclk) begin
    if (!resetn) begin
      on_reg <= 28'h0000000;
      off_reg <= 28'h0000000;
      drift_reg <= 28'h0000000;
      lock_reg <= 28'h0000000;
      cand_reg <= 1'b0;
      held_reg <= 1'b0;
      lifted_reg <= 1'b1;
      prev_reg <= 1'b0;
      key_press <= 1'b0;
      key_hold <= 1'b0;
      key_lift <= 1'b0;
      recal_pulse <= 1'b0;
      key_locked <= 1'b0;
    end else begin
      key_press <= 1'b0;
      key_hold <= 1'b0;
      key_lift <= 1'b0;
      recal_pulse <= 1'b0;
      prev_reg <= touch;
      // A bad unlock restarts the lockout even while already locked.
      if (bad_unlock) begin
        key_locked <= 1'b1;
        lock_reg <= LOCK_CYC[27:0];
      end else if (key_locked) begin
        if (lock_reg <= 28'h0000001) begin
          key_locked <= 1'b0;
        end
        lock_reg <= lock_reg - 28'h0000001;
      end
      if (drift_flag) begin
        if (drift_reg == GONE_CYC[27:0] - 28'h0000001) begin
          recal_pulse <= 1'b1;
          drift_reg <= 28'h0000000;
        end else begin
          drift_reg <= drift_reg + 28'h0000001;
        end
      end else begin
        drift_reg <= 28'h0000000;
      end
      if (touch) begin
        off_reg <= 28'h0000000;
        lifted_reg <= 1'b0;
        if (!prev_reg) begin
          cand_reg <= (off_reg >= PMIN_CYC[27:0]) | lifted_reg;
          on_reg <= 28'h0000001;
        end else if (on_reg != 28'hFFFFFFF) begin
          on_reg <= on_reg + 28'h0000001;
        end
        if (on_reg == HOLD_CYC[27:0] && !held_reg) begin
          key_hold <= 1'b1;
          held_reg <= 1'b1;
        end
        if (on_reg == GONE_CYC[27:0]) begin
          recal_pulse <= 1'b1;
        end
      end else begin
        held_reg <= 1'b0;
        if (off_reg != 28'hFFFFFFF) begin
          off_reg <= off_reg + 28'h0000001;
        end
        if (prev_reg) begin
          cand_reg <= cand_reg & (on_reg >= PMIN_CYC[27:0]) & (on_reg <= PMAX_CYC[27:0]);
        end
        // The press is only reported once the release itself is long enough.
        if (off_reg == PMIN_CYC[27:0] && cand_reg) begin
          key_press <= 1'b1;
          cand_reg <= 1'b0;
        end
        if (off_reg == LIFT_CYC[27:0] && !lifted_reg) begin
          key_lift <= 1'b1;
          lifted_reg <= 1'b1;
        end
      end
    end
  end
endmodule // psol_keypad
`default_nettype wire

/* File: core/psol_top.v */
// Switching output, analog output and indicator lamps of the position sensor.
`timescale 1ns/1ps
`default_nettype none
`include "psol_defs.vh"
module psol_top #(
  parameter GONE_CYC = `PSOL_TOUCH_GONE_CYC,
  parameter LOCK_CYC = `PSOL_LOCK_CYC,
  parameter HOLD_CYC = `PSOL_HOLD_CYC,
  parameter LIFT_CYC = `PSOL_LIFT_CYC,
  parameter PMIN_CYC = `PSOL_PRESS_MIN_CYC,
  parameter PMAX_CYC = `PSOL_PRESS_MAX_CYC
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [15:0] position,
  input  wire        sample_valid,
  input  wire        magnet_present,
  input  wire [15:0] working_range,
  input  wire [15:0] first_switch_point,
  input  wire [15:0] second_switch_point,
  input  wire [15:0] hyst_cfg,
  input  wire        hyst_load,
  input  wire [1:0]  mode_cfg,
  input  wire        mode_load,
  input  wire        mode_from_link,
  input  wire        switch_invert,
  input  wire        analog_invert,
  input  wire        current_select,
  input  wire        link_active,
  input  wire        link_cyclic,
  input  wire        dev_ready,
  input  wire        dev_error,
  input  wire        overload_pin,
  input  wire        touch_pin,
  input  wire        drift_pin,
  input  wire        bad_unlock,
  output reg         switch_out,
  output reg  [11:0] analog_level,
  output reg         analog_enable,
  output reg         lamp1_current,
  output reg         lamp1_voltage,
  output reg         second_indicator_lamp,
  output reg         magnet_in_range,
  output wire        key_press,
  output wire        key_hold,
  output wire        key_lift,
  output wire        recal_pulse,
  output wire        key_locked
);
  localparam ST_INIT  = 2'b01;
  localparam ST_VALID = 2'b10;

  reg  [1:0]  st_reg;
  reg  [1:0]  touch_s1_reg;
  reg  [1:0]  touch_s2_reg;
  reg  [1:0]  ovl_s1_reg;
  reg  [15:0] hyst_reg;
  reg  [1:0]  mode_reg;
  reg         norm_reg;
  reg         norm_next;
  reg  [22:0] err_cnt_reg;
  reg  [22:0] link_cnt_reg;
  reg  [22:0] ovl_cnt_reg;
  reg         err_blink_reg;
  reg         link_blink_reg;
  reg         ovl_blink_reg;
  reg  [11:0] level_next;
  wire [16:0] p  = {1'b0, position};
  wire [16:0] a1 = {1'b0, first_switch_point};
  wire [16:0] a2 = {1'b0, second_switch_point};
  wire [16:0] h  = {1'b0, hyst_reg};
  wire [16:0] cb = {1'b0, `PSOL_CYL_HALF};
  wire [16:0] lo_pt = (a1 < a2) ? a1 : a2;
  wire [16:0] hi_pt = (a1 < a2) ? a2 : a1;
  wire [31:0] scaled = position * {4'h0, `PSOL_AOUT_FS};
  wire [31:0] quot;
  wire [15:0] frac;
  wire [31:0] ma_span = frac * {4'h0, `PSOL_AOUT_FS - `PSOL_AOUT_4MA};
  // Dividing by full scale instead of shifting lets the current scale reach both ends exactly.
  wire [31:0] ma_div  = ma_span / 32'h00000FFF;

  // Band test with hysteresis: inside band or, if already active, inside widened band.
  function band;
    input [16:0] pos;
    input [16:0] lo;
    input [16:0] hi;
    input [16:0] hy;
    input        act;
    begin
      if (act) begin
        band = (pos + hy >= lo) && (pos <= hi + hy);
      end else begin
        band = (pos >= lo) && (pos <= hi);
      end
    end
  endfunction

  // A zero working range would divide by zero, so the output then rests at the level for position zero.
  assign quot = (working_range == 16'h0000) ? 32'h00000000 : scaled / {16'h0000, working_range};
  // Positions past the working range saturate at full scale.
  assign frac = (quot > 32'h00000FFF) ? 16'h0FFF : quot[15:0];

  always @(posedge mclk) begin
    if (!resetn) begin
      touch_s1_reg <= 2'b00;
      touch_s2_reg <= 2'b00;
      ovl_s1_reg <= 2'b00;
    end else begin
      touch_s1_reg <= {drift_pin, touch_pin};
      touch_s2_reg <= touch_s1_reg;
      ovl_s1_reg <= {ovl_s1_reg[0], overload_pin};
    end
  end

  psol_keypad #(
    .GONE_CYC (GONE_CYC),
    .LOCK_CYC (LOCK_CYC),
    .HOLD_CYC (HOLD_CYC),
    .LIFT_CYC (LIFT_CYC),
    .PMIN_CYC (PMIN_CYC),
    .PMAX_CYC (PMAX_CYC)
  ) u_keypad (
    .mclk        (mclk),
    .resetn      (resetn),
    .touch_sync  (touch_s2_reg[0]),
    .drift_flag  (touch_s2_reg[1]),
    .bad_unlock  (bad_unlock),
    .key_press   (key_press),
    .key_hold    (key_hold),
    .key_lift    (key_lift),
    .recal_pulse (recal_pulse),
    .key_locked  (key_locked)
  );

  // Configuration registers: hysteresis is clamped so bad link writes stay usable.
  always @(posedge mclk) begin
    if (!resetn) begin
      hyst_reg <= `PSOL_HYST_RST;
      mode_reg <= `PSOL_MODE_SINGLE;
    end else begin
      if (hyst_load) begin
        if (hyst_cfg < `PSOL_HYST_MIN) begin
          hyst_reg <= `PSOL_HYST_MIN;
        end else if (hyst_cfg > `PSOL_HYST_MAX) begin
          hyst_reg <= `PSOL_HYST_MAX;
        end else begin
          hyst_reg <= hyst_cfg;
        end
      end
      if (mode_load && (mode_cfg != `PSOL_MODE_TWOPT || mode_from_link)) begin
        mode_reg <= mode_cfg;
      end
    end
  end

  always @* begin
    norm_next = norm_reg;
    case (mode_reg)
      `PSOL_MODE_SINGLE: begin
        if (norm_reg) begin
          norm_next = p < a1;
        end else begin
          norm_next = p + h < a1;
        end
      end
      `PSOL_MODE_CYL: begin
        norm_next = band(p, (a1 > cb) ? a1 - cb : 17'h00000, a1 + cb, h, norm_reg);
      end
      `PSOL_MODE_WINDOW: begin
        norm_next = band(p, lo_pt, hi_pt, h, norm_reg);
      end
      `PSOL_MODE_TWOPT: begin
        if (p >= hi_pt) begin
          norm_next = 1'b1;
        end else if (p <= lo_pt) begin
          norm_next = 1'b0;
        end
      end
      default: begin
        norm_next = 1'b0;
      end
    endcase
  end

  // The switching state only moves on a fresh sample, so held values never chatter.
  always @(posedge mclk) begin
    if (!resetn) begin
      st_reg <= ST_INIT;
      norm_reg <= 1'b0;
      magnet_in_range <= 1'b0;
    end else begin
      case (st_reg)
        ST_INIT: begin
          if (sample_valid) begin
            st_reg <= ST_VALID;
            magnet_in_range <= magnet_present;
            norm_reg <= norm_next;
          end
        end
        ST_VALID: begin
          if (sample_valid) begin
            magnet_in_range <= magnet_present;
            norm_reg <= norm_next;
          end
        end
        default: begin
          st_reg <= ST_INIT;
        end
      endcase
    end
  end

  always @* begin
    if (current_select) begin
      level_next = `PSOL_AOUT_4MA + ma_div[11:0];
    end else begin
      level_next = frac[11:0];
    end
    if (analog_invert) begin
      if (current_select) begin
        level_next = `PSOL_AOUT_FS - ma_div[11:0];
      end else begin
        level_next = `PSOL_AOUT_FS - frac[11:0];
      end
    end
  end

  always @(posedge mclk) begin
    if (!resetn) begin
      err_cnt_reg <= 23'h000000;
      link_cnt_reg <= 23'h000000;
      ovl_cnt_reg <= 23'h000000;
      err_blink_reg <= 1'b0;
      link_blink_reg <= 1'b0;
      ovl_blink_reg <= 1'b0;
      switch_out <= 1'b0;
      analog_level <= 12'h000;
      analog_enable <= 1'b0;
      lamp1_current <= 1'b0;
      lamp1_voltage <= 1'b0;
      second_indicator_lamp <= 1'b0;
    end else begin
      if (err_cnt_reg == `PSOL_ERR_HALF_CYC - 1) begin
        err_cnt_reg <= 23'h000000;
        err_blink_reg <= ~err_blink_reg;
      end else begin
        err_cnt_reg <= err_cnt_reg + 23'h000001;
      end
      if (link_cnt_reg == `PSOL_LINK_HALF_CYC - 1) begin
        link_cnt_reg <= 23'h000000;
        link_blink_reg <= ~link_blink_reg;
      end else begin
        link_cnt_reg <= link_cnt_reg + 23'h000001;
      end
      if (ovl_cnt_reg == `PSOL_OVL_HALF_CYC - 1) begin
        ovl_cnt_reg <= 23'h000000;
        ovl_blink_reg <= ~ovl_blink_reg;
      end else begin
        ovl_cnt_reg <= ovl_cnt_reg + 23'h000001;
      end
      switch_out <= norm_reg ^ switch_invert;
      analog_enable <= dev_ready & ~link_cyclic;
      analog_level <= (link_cyclic) ? 12'h000 : level_next;
      // Lamp one shows readiness; the link blink overrides the steady colour.
      lamp1_current <= dev_ready & current_select & (~link_active | link_blink_reg);
      lamp1_voltage <= dev_ready & ~current_select & (~link_active | link_blink_reg);
      if (dev_error) begin
        second_indicator_lamp <= err_blink_reg;
      end else if (ovl_s1_reg[1]) begin
        second_indicator_lamp <= ovl_blink_reg;
      end else begin
        second_indicator_lamp <= (norm_reg ^ switch_invert) | magnet_in_range;
      end
    end
  end
endmodule // psol_top
`default_nettype wire

/* File: verification/psol_assertions.sv */
// Concurrent checks on the ports of the position switch output logic.
`timescale 1ns/1ps
`default_nettype none
module psol_checker #(
  parameter LOCK_CYC = 30
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        sample_valid,
  input wire logic        mode_load,
  input wire logic        hyst_load,
  input wire logic        switch_invert,
  input wire logic [15:0] first_switch_point,
  input wire logic [15:0] second_switch_point,
  input wire logic        link_cyclic,
  input wire logic        link_active,
  input wire logic        dev_ready,
  input wire logic        dev_error,
  input wire logic        current_select,
  input wire logic        overload_pin,
  input wire logic        touch_pin,
  input wire logic        drift_pin,
  input wire logic        bad_unlock,
  input wire logic        switch_out,
  input wire logic        analog_enable,
  input wire logic        lamp1_current,
  input wire logic        second_indicator_lamp,
  input wire logic        magnet_in_range,
  input wire logic        key_hold,
  input wire logic        recal_pulse,
  input wire logic        key_locked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [31:0] lock_cnt;
  // A counter bounds the lockout, since a repetition that long would crawl.
  always @(posedge mclk) begin
    if (!resetn || !key_locked) lock_cnt <= 32'h0;
    else lock_cnt <= lock_cnt + 32'h1;
  end
  range_sample_a: assert property ($rose(magnet_in_range) |-> $past(sample_valid))
    else $error("magnet flag rose without sample");
  lock_start_a: assert property (bad_unlock && !key_locked |-> ##[1:3] key_locked)
    else $error("lockout did not start");
  lock_len_a: assert property (lock_cnt <= LOCK_CYC + 2)
    else $error("lockout too long");
  hold_cause_a: assert property (key_hold |-> $past(touch_pin, 5))
    else $error("hold without contact");
  recal_cause_a: assert property (recal_pulse |-> $past(touch_pin, 5) || $past(drift_pin, 5))
    else $error("recalibration without cause");
  analog_off_a: assert property (link_cyclic [*3] |-> !analog_enable)
    else $error("analog on during cyclic link");
  lamp_switch_a: assert property ((switch_out && !dev_error && !overload_pin) [*5] |-> second_indicator_lamp)
    else $error("lamp two dark with output high");
  lamp_off_a: assert property ((!switch_out && !magnet_in_range && !dev_error && !overload_pin) [*5]
    |-> !second_indicator_lamp)
    else $error("lamp two lit with magnet out");
  lamp1_sel_a: assert property ((dev_ready && !dev_error && !link_active && current_select) [*4]
    |-> lamp1_current)
    else $error("current indication missing");
  switch_hold_a: assert property ((resetn && !sample_valid && !mode_load && !hyst_load
    && $stable(switch_invert) && $stable(first_switch_point) && $stable(second_switch_point)) [*4]
    |=> $stable(switch_out))
    else $error("output moved without cause");
  cover property (key_locked);
  cover property (recal_pulse);
  cover property (switch_out && analog_enable);
endmodule // psol_checker
bind psol_top psol_checker #(.LOCK_CYC(LOCK_CYC)) u_psol_checker (.mclk, .resetn, .sample_valid,
  .mode_load, .hyst_load, .switch_invert, .first_switch_point, .second_switch_point, .link_cyclic,
  .link_active, .dev_ready, .dev_error, .current_select, .overload_pin, .touch_pin, .drift_pin,
  .bad_unlock, .switch_out, .analog_enable, .lamp1_current, .second_indicator_lamp,
  .magnet_in_range, .key_hold, .recal_pulse, .key_locked);
`default_nettype wire

/* File: verification/psol_ctrl_model.sv */
// Machine controller model that reads the analog output.
`timescale 1ns/1ps
`default_nettype none
module psol_ctrl_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        analog_enable,
  input  wire logic [11:0] analog_level,
  output var  logic [11:0] ana_seen
);
  // A disabled analog line means nothing, so the last good reading is kept.
  always @(posedge mclk) begin
    if (!resetn) ana_seen <= 12'h000;
    else if (analog_enable) ana_seen <= analog_level;
  end
endmodule // psol_ctrl_model
`default_nettype wire

/* File: verification/psol_tb_top.sv */
// Self-checking testbench for the position switch output logic.
`timescale 1ns/1ps
`default_nettype none
module position_switch_output_logic_tb_top;
  localparam int LOCK = 30;
  logic        mclk, resetn, sample_valid, magnet_present, hyst_load, mode_load, mode_from_link;
  logic        switch_invert, analog_invert, current_select, link_active, link_cyclic;
  logic        dev_ready, dev_error, overload_pin, touch_pin, drift_pin, bad_unlock;
  logic [15:0] position, working_range, first_switch_point, second_switch_point, hyst_cfg;
  logic [1:0]  mode_cfg;
  wire         switch_out, analog_enable, lamp1_current, lamp1_voltage, second_indicator_lamp;
  wire         magnet_in_range, key_press, key_hold, key_lift, recal_pulse, key_locked;
  wire  [11:0] analog_level, ana_seen;
  int          fails, n_compared, cycles, n_hold, n_recal, n_lift, n_press, b;
  psol_top #(.GONE_CYC(50), .LOCK_CYC(LOCK), .HOLD_CYC(20), .LIFT_CYC(20), .PMIN_CYC(4),
    .PMAX_CYC(10)) u_psol_top (.mclk,
    .resetn, .position, .sample_valid, .magnet_present, .working_range, .first_switch_point,
    .second_switch_point, .hyst_cfg, .hyst_load, .mode_cfg, .mode_load, .mode_from_link,
    .switch_invert, .analog_invert, .current_select, .link_active, .link_cyclic, .dev_ready,
    .dev_error, .overload_pin, .touch_pin, .drift_pin, .bad_unlock, .switch_out, .analog_level,
    .analog_enable, .lamp1_current, .lamp1_voltage, .second_indicator_lamp, .magnet_in_range,
    .key_press, .key_hold, .key_lift, .recal_pulse, .key_locked);
  psol_ctrl_model u_psol_ctrl_model (.mclk, .resetn, .analog_enable, .analog_level, .ana_seen);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    n_hold <= n_hold + int'(key_hold);
    n_recal <= n_recal + int'(recal_pulse);
    n_lift <= n_lift + int'(key_lift);
    n_press <= n_press + int'(key_press);
    if (cycles == 20000) begin
      fails = fails + 1;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic smp(input logic [15:0] p, input logic m);
    @(posedge mclk);
    position <= p;
    magnet_present <= m;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    cyc(3);
  endtask
  task automatic sw(input logic [15:0] p, input logic e);
    smp(p, 1'b1);
    chk({15'h0, switch_out}, {15'h0, e}, "switch");
  endtask
  task automatic an(input logic [15:0] p, input logic [11:0] e);
    smp(p, 1'b1);
    chk({4'h0, ana_seen}, {4'h0, e}, "analog");
  endtask
  task automatic ldm(input logic [1:0] m, input logic f);
    @(posedge mclk);
    mode_cfg <= m;
    mode_from_link <= f;
    mode_load <= 1'b1;
    @(posedge mclk);
    mode_load <= 1'b0;
    mode_from_link <= 1'b0;
  endtask
  task automatic ldh(input logic [15:0] h);
    @(posedge mclk);
    hyst_cfg <= h;
    hyst_load <= 1'b1;
    @(posedge mclk);
    hyst_load <= 1'b0;
  endtask
  initial begin
    {resetn, sample_valid, magnet_present, hyst_load, mode_load, mode_from_link} = 6'h00;
    {switch_invert, analog_invert, link_active, link_cyclic, dev_error} = 5'h00;
    {overload_pin, touch_pin, drift_pin, bad_unlock, mode_cfg} = 6'h00;
    {current_select, dev_ready} = 2'h3;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    n_hold = 0;
    n_recal = 0;
    n_lift = 0;
    n_press = 0;
    position = 16'h0000;
    working_range = 16'h03E8;
    hyst_cfg = 16'h0032;
    // Points sit clear of zero by more than the hysteresis; the first equals the working range.
    first_switch_point = 16'h03E8;
    second_switch_point = 16'h07D0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    cyc(2);
    chk({15'h0, magnet_in_range}, 16'h0000, "range");
    sw(16'h0384, 1'b1);
    sw(16'h03CA, 1'b1);
    sw(16'h03E8, 1'b0);
    sw(16'h03CA, 1'b0);
    sw(16'h03AC, 1'b1);
    switch_invert <= 1'b1;
    sw(16'h03AC, 1'b0);
    switch_invert <= 1'b0;
    ldh(16'h0001);
    sw(16'h03E8, 1'b0);
    sw(16'h03E5, 1'b0);
    sw(16'h03E2, 1'b1);
    ldh(16'hFFFF);
    first_switch_point <= 16'h0BB8;
    sw(16'h0BB8, 1'b0);
    sw(16'h05DC, 1'b0);
    sw(16'h0384, 1'b1);
    ldh(16'h0032);
    first_switch_point <= 16'h03E8;
    ldm(2'h1, 1'b0);
    sw(16'h03E8, 1'b1);
    sw(16'h0514, 1'b0);
    sw(16'h0190, 1'b0);
    ldm(2'h2, 1'b0);
    first_switch_point <= 16'h01F4;
    second_switch_point <= 16'h05DC;
    sw(16'h03E8, 1'b1);
    sw(16'h00C8, 1'b0);
    sw(16'h0708, 1'b0);
    sw(16'h03E8, 1'b1);
    ldm(2'h3, 1'b0);
    sw(16'h0708, 1'b0);
    ldm(2'h3, 1'b1);
    sw(16'h0708, 1'b1);
    sw(16'h03E8, 1'b1);
    sw(16'h00C8, 1'b0);
    sw(16'h03E8, 1'b0);
    ldm(2'h0, 1'b0);
    first_switch_point <= 16'h03E8;
    smp(16'h0708, 1'b1);
    chk({15'h0, second_indicator_lamp}, 16'h0001, "lamp2 in");
    smp(16'h0708, 1'b0);
    chk({15'h0, magnet_in_range}, 16'h0000, "range out");
    chk({15'h0, second_indicator_lamp}, 16'h0000, "lamp2 out");
    chk({14'h0, lamp1_current, lamp1_voltage}, 16'h0002, "lamp1 cur");
    current_select <= 1'b0;
    an(16'h0000, 12'h000);
    chk({14'h0, lamp1_current, lamp1_voltage}, 16'h0001, "lamp1 volt");
    an(16'h03E8, 12'hFFF);
    analog_invert <= 1'b1;
    an(16'h0000, 12'hFFF);
    an(16'h03E8, 12'h000);
    current_select <= 1'b1;
    an(16'h03E8, 12'h333);
    analog_invert <= 1'b0;
    an(16'h0000, 12'h333);
    an(16'h03E8, 12'hFFF);
    chk({15'h0, analog_enable}, 16'h0001, "aen");
    link_cyclic <= 1'b1;
    an(16'h0000, 12'hFFF);
    chk({15'h0, analog_enable}, 16'h0000, "aen cyc");
    link_cyclic <= 1'b0;
    b = n_hold;
    @(posedge mclk);
    bad_unlock <= 1'b1;
    touch_pin <= 1'b1;
    @(posedge mclk);
    bad_unlock <= 1'b0;
    cyc(3);
    chk({15'h0, key_locked}, 16'h0001, "locked");
    cyc(20);
    touch_pin <= 1'b0;
    cyc(LOCK);
    chk({15'h0, key_locked}, 16'h0000, "unlocked");
    chk(16'(n_hold), 16'(b), "hold locked");
    cyc(30);
    b = n_recal;
    touch_pin <= 1'b1;
    cyc(60);
    touch_pin <= 1'b0;
    chk(16'(n_recal), 16'(b + 1), "recal touch");
    b = n_lift;
    cyc(35);
    chk(16'(n_lift), 16'(b + 1), "lift");
    chk(16'(n_hold), 16'h0001, "hold");
    b = n_recal;
    drift_pin <= 1'b1;
    cyc(60);
    drift_pin <= 1'b0;
    cyc(5);
    chk(16'(n_recal), 16'(b + 1), "recal drift");
    touch_pin <= 1'b1;
    cyc(6);
    touch_pin <= 1'b0;
    cyc(12);
    chk(16'(n_press), 16'h0001, "press");
    smp(16'h0708, 1'b1);
    dev_error <= 1'b1;
    cyc(3);
    chk({15'h0, second_indicator_lamp}, 16'h0000, "lamp2 err");
    dev_error <= 1'b0;
    overload_pin <= 1'b1;
    cyc(5);
    chk({15'h0, second_indicator_lamp}, 16'h0000, "lamp2 ovl");
    overload_pin <= 1'b0;
    link_active <= 1'b1;
    cyc(5);
    chk({14'h0, lamp1_current, lamp1_voltage}, 16'h0000, "lamp1 link");
    chk({15'h0, second_indicator_lamp}, 16'h0001, "lamp2 back");
    link_active <= 1'b0;
    cyc(3);
    chk({14'h0, lamp1_current, lamp1_voltage}, 16'h0002, "lamp1 back");
    end_sim();
  end
endmodule // position_switch_output_logic_tb_top
`default_nettype wire
